// ==== verilog/dtp_pkg.sv ====
package dtp_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses on the APB)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_DOWN_COUNT   = 8'h00; // down_count_register
    localparam logic [7:0] OFF_CTRL_ONE     = 8'h04; // counter_control_one
    localparam logic [7:0] OFF_CTRL_TWO     = 8'h08; // counter_control_two
    localparam logic [7:0] OFF_PRESC_LIVE   = 8'h0C; // prescale_live_value
    localparam logic [7:0] OFF_PULSE_DUTY   = 8'h10; // pulse_duty_register
    localparam logic [7:0] OFF_TONE_CTRL    = 8'h14; // tone_control_register
    localparam logic [7:0] OFF_IRQ_FLAG     = 8'h18; // irq_flag_register
    localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h1C; // irq_enable_register

    // ---------------------------------------------------------------
    // field positions and constants
    // ---------------------------------------------------------------
    localparam int         FLAG_UNDERFLOW_BIT = 3;  // underflow_flag
    localparam int         GLOBAL_ENABLE_BIT  = 7;  // global_irq_enable
    localparam logic [7:0] COUNT_WRAP_VALUE   = 8'hFF;
    localparam logic [7:0] COUNT_ZERO         = 8'h00;
    localparam logic [7:0] CTRL_ONE_RST       = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST       = 8'h08; // prescaler bypassed
    localparam logic [7:0] TONE_CTRL_RST      = 8'h00;
    localparam logic [7:0] BYTE_ZERO          = 8'h00;
    localparam logic [3:0] PRESC_SHIFT_BASE   = 4'h1; // code 0 means 1:2

    // ---------------------------------------------------------------
    // control register layouts
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       pulse_out_enable;   // bit 7
        logic       pulse_active_low;   // bit 6
        logic [2:0] unused;             // bits 5..3, read as zero
        logic       single_pass_select; // bit 2
        logic       reload_on_wrap;     // bit 1
        logic       counter_run_enable; // bit 0
    } dtp_ctrl_one_t;

    typedef struct packed {
        logic [1:0] unused;                // bits 7..6
        logic       count_source_select;   // bit 5
        logic       pin_edge_select;       // bit 4
        logic       prescale_enable_n;     // bit 3
        logic [2:0] prescale_ratio_select; // bits 2..0
    } dtp_ctrl_two_t;

    typedef struct packed {
        logic       tone_out_enable;  // bit 7
        logic [2:0] unused;           // bits 6..4
        logic [3:0] tone_rate_select; // bit 3 picks source
    } dtp_tone_ctrl_t;

endpackage : dtp_pkg

// ==== verilog/dtp_down_timer.sv ====
`timescale 1ns/1ps
module dtp_down_timer
    import dtp_pkg::*;
#(
    parameter int ADDR_W = 8 // apb address width
)(
    input  wire logic              CORE_CLK,
    input  wire logic              SRST,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              EXTERNAL_COUNT_PIN,
    output logic                   PULSE_PIN_O,
    output logic                   PULSE_PIN_OE,
    output logic                   TONE_PIN_O,
    output logic                   TONE_PIN_OE,
    output logic                   IRQ
);

    // ---------------------------------------------------------------
    // elaboration check
    // ---------------------------------------------------------------
    if (ADDR_W < 5 || ADDR_W > 8)
    begin : g_bad_addr
        $error("dtp_down_timer: ADDR_W must be 5 to 8");
    end

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    // true when the low k bits of cnt are all ones (k up to 8)
    function automatic logic pow2_hit(input logic [7:0] cnt,
                                      input logic [3:0] k);
        logic [8:0] mask;
        mask = (9'h001 << k) - 9'h001;
        return (({1'b0, cnt} | ~mask) == 9'h1FF);
    endfunction : pow2_hit

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    dtp_ctrl_one_t  ctrl_one;       // counter_control_one
    dtp_ctrl_two_t  ctrl_two;       // counter_control_two
    dtp_tone_ctrl_t tone_ctrl;      // tone_control_register
    logic [7:0]     down_count;     // live count
    logic [7:0]     reload_value;   // reload_value_register
    logic [7:0]     pulse_duty;     // pulse_duty_register
    logic [7:0]     presc_count;    // prescale_live_value
    logic [7:0]     tone_count;     // tone divider
    logic           tone_level;     // square wave before pin
    logic           stopped;        // single pass has finished
    logic           underflow_flag; // sticky event bit
    logic [7:0]     irq_enable;     // irq_enable_register
    logic           pin_s1;         // synchroniser stage 1
    logic           pin_s2;         // synchroniser stage 2
    logic           pin_s3;         // synchroniser stage 3
    logic           pin_level;      // accepted pin level

    // ---------------------------------------------------------------
    // apb access decode
    // ---------------------------------------------------------------
    logic [7:0] addr8;      // address widened to the map width
    logic       access;     // access phase completing this edge
    logic       wr;         // completing write
    logic [7:0] wbyte;      // low write byte

    assign addr8  = 8'(PADDR);
    assign access = PSEL & PENABLE & PREADY;
    assign wr     = access & PWRITE;
    assign wbyte  = PWDATA[7:0];

    logic wr_count;         // write to down_count_register
    assign wr_count = wr && (addr8 == OFF_DOWN_COUNT);

    // ---------------------------------------------------------------
    // count source and prescaler
    // ---------------------------------------------------------------
    logic pin_edge;         // selected pin transition
    logic src_tick;         // selected source pulse
    logic presc_hit;        // prescaler terminal point
    logic count_tick;       // counter input clock
    logic underflow;        // counter passes below zero

    // a change counts once stages 2 and 3 agree on a new level;
    // stage 1 may be metastable, so it is never compared
    assign pin_edge = (pin_s2 == pin_s3) & (pin_s3 != pin_level) &
                      (ctrl_two.pin_edge_select ? ~pin_s3
                                                : pin_s3);
    // instruction clock is one pulse per core cycle
    assign src_tick = ctrl_one.counter_run_enable &
                      (ctrl_two.count_source_select ? pin_edge
                                                    : 1'b1);
    // code n divides by two to the n+1
    assign presc_hit = pow2_hit(presc_count,
                                {1'b0, ctrl_two.prescale_ratio_select}
                                + PRESC_SHIFT_BASE);
    assign count_tick = src_tick &
                        (ctrl_two.prescale_enable_n | presc_hit);
    assign underflow = count_tick & ~stopped & (down_count == COUNT_ZERO);

    // three-stage synchroniser for the external count pin
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3    <= 1'b0;
            pin_level <= 1'b0;
        end
        else
        begin
            pin_s1 <= EXTERNAL_COUNT_PIN;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            // level moves only when both late stages agree
            if (pin_s2 == pin_s3)
                pin_level <= pin_s3;
        end
    end

    // prescaler counter, cleared whenever its setup is rewritten
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
            presc_count <= BYTE_ZERO;
        else if (wr && addr8 == OFF_CTRL_TWO)
            presc_count <= BYTE_ZERO;
        else if (src_tick && !ctrl_two.prescale_enable_n)
            presc_count <= presc_count + 8'h01;
    end

    // ---------------------------------------------------------------
    // down counter
    // ---------------------------------------------------------------
    // a software write wins over a tick in the same cycle
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            down_count   <= COUNT_ZERO;
            reload_value <= COUNT_ZERO;
            stopped      <= 1'b0;
        end
        else if (wr_count)
        begin
            down_count   <= wbyte;
            reload_value <= wbyte;
            stopped      <= 1'b0;
        end
        else if (underflow)
        begin
            if (ctrl_one.single_pass_select)
                stopped <= 1'b1;
            else if (ctrl_one.reload_on_wrap)
                down_count <= reload_value;
            else
                down_count <= COUNT_WRAP_VALUE;
        end
        else if (count_tick && !stopped)
            down_count <= down_count - 8'h01;
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    // unused fields are forced to zero so they read back as zero
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            ctrl_one   <= dtp_ctrl_one_t'(CTRL_ONE_RST);
            ctrl_two   <= dtp_ctrl_two_t'(CTRL_TWO_RST);
            tone_ctrl  <= dtp_tone_ctrl_t'(TONE_CTRL_RST);
            pulse_duty <= BYTE_ZERO;
            irq_enable <= BYTE_ZERO;
        end
        else if (wr)
        begin
            case (addr8)
                OFF_CTRL_ONE:
                begin
                    ctrl_one        <= dtp_ctrl_one_t'(wbyte);
                    ctrl_one.unused <= 3'h0;
                end
                OFF_CTRL_TWO:
                begin
                    ctrl_two        <= dtp_ctrl_two_t'(wbyte);
                    ctrl_two.unused <= 2'h0;
                end
                OFF_TONE_CTRL:
                begin
                    tone_ctrl        <= dtp_tone_ctrl_t'(wbyte);
                    tone_ctrl.unused <= 3'h0;
                end
                OFF_PULSE_DUTY: pulse_duty <= wbyte;
                OFF_IRQ_ENABLE: irq_enable <= wbyte;
                default: ; // other offsets hold no control state
            endcase
        end
    end

    // ---------------------------------------------------------------
    // interrupt flag and request
    // ---------------------------------------------------------------
    // writing zero clears; an underflow in that cycle still sets it
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
            underflow_flag <= 1'b0;
        else if (underflow)
            underflow_flag <= 1'b1;
        else if (wr && addr8 == OFF_IRQ_FLAG && !wbyte[FLAG_UNDERFLOW_BIT])
            underflow_flag <= 1'b0;
    end

    // level request, gated by the unit and global enables
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
            IRQ <= 1'b0;
        else
            IRQ <= underflow_flag & irq_enable[FLAG_UNDERFLOW_BIT]
                   & irq_enable[GLOBAL_ENABLE_BIT];
    end

    // ---------------------------------------------------------------
    // pulse-width output
    // ---------------------------------------------------------------
    // active while count is below duty: duty 0 never, 0xFF for 255
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            PULSE_PIN_O  <= 1'b0;
            PULSE_PIN_OE <= 1'b0;
        end
        else
        begin
            PULSE_PIN_O  <= (down_count < pulse_duty)
                            ^ ctrl_one.pulse_active_low;
            PULSE_PIN_OE <= ctrl_one.pulse_out_enable;
        end
    end

    // ---------------------------------------------------------------
    // tone output
    // ---------------------------------------------------------------
    logic tone_src;         // selected tone source pulse
    logic tone_hit;         // divided tone pulse

    assign tone_src = tone_ctrl.tone_rate_select[3] ? underflow
                                                    : count_tick &
                      ~ctrl_two.prescale_enable_n |
                      (src_tick & ctrl_two.prescale_enable_n);
    // the toggle doubles the ratio: codes give 1:2 up to 1:256
    assign tone_hit = tone_src &
                      pow2_hit(tone_count,
                               {1'b0, tone_ctrl.tone_rate_select[2:0]});

    // divider count and square wave toggle
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            tone_count <= BYTE_ZERO;
            tone_level <= 1'b0;
        end
        else if (tone_src)
        begin
            tone_count <= tone_count + 8'h01;
            if (tone_hit)
                tone_level <= ~tone_level;
        end
    end

    // pin drivers for the tone
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            TONE_PIN_O  <= 1'b0;
            TONE_PIN_OE <= 1'b0;
        end
        else
        begin
            TONE_PIN_O  <= tone_level;
            TONE_PIN_OE <= tone_ctrl.tone_out_enable;
        end
    end

    // ---------------------------------------------------------------
    // apb read path and handshake
    // ---------------------------------------------------------------
    logic [7:0] next_rbyte; // read byte chosen in the setup cycle
    logic       next_err;   // unmapped address

    always_comb
    begin
        next_rbyte = BYTE_ZERO;
        next_err   = 1'b0;
        case (addr8)
            OFF_DOWN_COUNT: next_rbyte = down_count;
            OFF_CTRL_ONE:   next_rbyte = ctrl_one;
            OFF_CTRL_TWO:   next_rbyte = ctrl_two;
            OFF_PRESC_LIVE: next_rbyte = presc_count;
            OFF_PULSE_DUTY: next_rbyte = pulse_duty;
            OFF_TONE_CTRL:  next_rbyte = tone_ctrl;
            OFF_IRQ_FLAG:   next_rbyte[FLAG_UNDERFLOW_BIT] = underflow_flag;
            OFF_IRQ_ENABLE: next_rbyte = irq_enable;
            default:        next_err   = 1'b1;
        endcase
    end

    // one wait-free access cycle; data captured at setup
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (PSEL && !PENABLE)
        begin
            PREADY  <= 1'b1;
            PRDATA  <= {24'h00_0000, next_rbyte};
            PSLVERR <= next_err;
        end
        else
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    a_count_load: assert property (wr_count |=>
        down_count == $past(wbyte) && reload_value == $past(wbyte))
        else $error("count write did not load both registers");
    a_run_gate: assert property (!ctrl_one.counter_run_enable &&
        !wr_count |=> $stable(down_count))
        else $error("counter moved while disabled");
    a_pin_source: assert property (ctrl_two.count_source_select &&
        (pin_s2 != pin_s3 || pin_s3 == pin_level) |-> !count_tick)
        else $error("counter ticked without a pin edge");
    a_single_stop: assert property (underflow &&
        ctrl_one.single_pass_select && !wr_count |=>
        stopped && down_count == COUNT_ZERO ##1 !underflow)
        else $error("single pass did not stop at zero");
    a_wrap_full: assert property (underflow && !wr_count &&
        !ctrl_one.single_pass_select && !ctrl_one.reload_on_wrap
        |=> down_count == COUNT_WRAP_VALUE)
        else $error("free run did not restart from full");
    a_wrap_reload: assert property (underflow && !wr_count &&
        !ctrl_one.single_pass_select && ctrl_one.reload_on_wrap
        |=> down_count == $past(reload_value))
        else $error("free run did not restart from reload");
    a_flag_irq: assert property (underflow &&
        irq_enable[FLAG_UNDERFLOW_BIT] && irq_enable[GLOBAL_ENABLE_BIT]
        && $stable(irq_enable) |=> underflow_flag ##1 IRQ)
        else $error("underflow did not raise the interrupt");
    a_global_gate: assert property (!irq_enable[GLOBAL_ENABLE_BIT]
        |=> !IRQ)
        else $error("interrupt raised with global enable off");
    a_duty_zero: assert property (pulse_duty == BYTE_ZERO
        |=> PULSE_PIN_O == $past(ctrl_one.pulse_active_low))
        else $error("pulse active with zero duty");
    a_pulse_dir: assert property (ctrl_one.pulse_out_enable
        |=> PULSE_PIN_OE)
        else $error("pulse pin not driven when enabled");
    a_tone_dir: assert property (tone_ctrl.tone_out_enable
        |=> TONE_PIN_OE)
        else $error("tone pin not driven when enabled");

    c_underflow: cover property (underflow ##1 underflow_flag);
    c_irq_rise: cover property ($rose(IRQ));
    c_single_done: cover property ($rose(stopped));
    c_tone_toggle: cover property ($changed(TONE_PIN_O) && TONE_PIN_OE);

endmodule : dtp_down_timer

// ==== tb/dtp_far_side.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// far side: count pin source, pulse load, buzzer
// ---------------------------------------------
module dtp_far_side (
    input  wire logic core_clk,
    input  wire logic pulse_level,
    input  wire logic tone_level,
    output logic      ext_pin
);
    int   hi_cnt;    // cycles with pulse pin high
    int   tog_cnt;   // tone level changes seen
    logic last_tone; // tone level one cycle back

    // idle low; the pin holds its level between drives
    initial ext_pin = 1'b0;

    // one level change, then hold long enough for the
    // three-stage synchroniser to settle
    task automatic drive_pin(input logic lvl);
        @(posedge core_clk);
        ext_pin <= lvl;
        repeat (8) @(posedge core_clk);
    endtask : drive_pin

    // load and buzzer: high time and toggle count over n cycles
    task automatic watch(input int n);
        hi_cnt = 0;
        tog_cnt = 0;
        last_tone = tone_level;
        repeat (n)
        begin
            @(posedge core_clk);
            if (pulse_level === 1'b1) hi_cnt++;
            if (tone_level !== last_tone) tog_cnt++;
            last_tone = tone_level;
        end
    endtask : watch
endmodule : dtp_far_side

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import dtp_pkg::*;
    // ---------------------------------------------
    // signals
    // ---------------------------------------------
    logic        clk = 1'b0; // 200 MHz core clock
    logic        srst;       // synchronous reset
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        prdy;
    logic        perr;
    logic        ext;        // count pin from the far side
    logic        po;
    logic        poe;
    logic        to;
    logic        toe;
    logic        irq;
    logic [7:0]  q;          // last read data
    logic [7:0]  a0;         // earlier read data
    logic        slv;        // last error response
    int          err_total = 0;
    int          tests_run = 0;
    int          cyc = 0;

    always #2.5 clk = ~clk;

    dtp_down_timer i_dut (
        .CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr),
        .EXTERNAL_COUNT_PIN(ext), .PULSE_PIN_O(po),
        .PULSE_PIN_OE(poe), .TONE_PIN_O(to), .TONE_PIN_OE(toe),
        .IRQ(irq)
    );

    dtp_far_side i_far (
        .core_clk(clk), .pulse_level(po), .tone_level(to),
        .ext_pin(ext)
    );

    // ---------------------------------------------
    // tasks
    // ---------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer; starts on a fresh edge so the previous
    // release and this setup never land in one time step
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // PREADY ends this wait; only the bench timeout ends a hung one
        while (prdy !== 1'b1)
            @(posedge clk);
        q = prdata[7:0];
        slv = perr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, exp);
        xfer(1'b0, a, 8'h00);
        chk(nm, {8'h00, q}, {8'h00, exp});
    endtask : rd

    // write, settle, then watch the far side; sel picks toggles
    task automatic meas(input logic [7:0] a, d, input logic sel,
                        input int n, input logic [15:0] exp);
        wr(a, d);
        repeat (10) @(posedge clk);
        i_far.watch(n);
        chk(sel ? "toggles" : "high", 16'(sel ? i_far.tog_cnt
                                              : i_far.hi_cnt), exp);
    endtask : meas

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // a hang costs one mismatch and ends the run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd("ctrl_two", OFF_CTRL_TWO, CTRL_TWO_RST);
        rd("ctrl_one", OFF_CTRL_ONE, CTRL_ONE_RST);
        xfer(1'b0, 8'h20, 8'h00);
        chk("unmapped", {7'h00, slv, q}, 16'h0100);
        // stopped counter keeps the written value
        wr(OFF_DOWN_COUNT, 8'h05);
        repeat (20) @(posedge clk);
        rd("held", OFF_DOWN_COUNT, 8'h05);
        // divide by 256: one tick, underflow, then 0xFF holds
        wr(OFF_CTRL_TWO, 8'h07);
        wr(OFF_DOWN_COUNT, 8'h01);
        wr(OFF_CTRL_ONE, 8'h01);
        repeat (600) @(posedge clk);
        rd("wrap", OFF_DOWN_COUNT, 8'hFF);
        rd("flag", OFF_IRQ_FLAG, 8'h08);
        xfer(1'b0, OFF_PRESC_LIVE, 8'h00);
        a0 = q;
        xfer(1'b0, OFF_PRESC_LIVE, 8'h00);
        // captures are three prescaler steps apart
        chk("presc_live", {8'h00, 8'(q - a0)}, 16'h0003);
        wr(OFF_CTRL_ONE, 8'h00);
        wr(OFF_IRQ_ENABLE, 8'h08);
        repeat (3) @(posedge clk);
        chk("irq_gated", {15'h0000, irq}, 16'h0000);
        wr(OFF_IRQ_ENABLE, 8'h88);
        repeat (3) @(posedge clk);
        chk("irq_on", {15'h0000, irq}, 16'h0001);
        wr(OFF_IRQ_FLAG, 8'h00);
        repeat (3) @(posedge clk);
        chk("irq_off", {15'h0000, irq}, 16'h0000);
        // single pass stops at zero and raises the flag once
        wr(OFF_CTRL_TWO, CTRL_TWO_RST);
        wr(OFF_DOWN_COUNT, 8'h03);
        wr(OFF_CTRL_ONE, 8'h05);
        repeat (40) @(posedge clk);
        rd("one_shot", OFF_DOWN_COUNT, 8'h00);
        chk("irq_once", {15'h0000, irq}, 16'h0001);
        wr(OFF_IRQ_FLAG, 8'h00);
        repeat (40) @(posedge clk);
        rd("no_refire", OFF_IRQ_FLAG, 8'h00);
        // count pin: falling edges first, then rising edges
        wr(OFF_CTRL_ONE, 8'h00);
        wr(OFF_CTRL_TWO, 8'h38);
        wr(OFF_DOWN_COUNT, 8'h10);
        wr(OFF_CTRL_ONE, 8'h01);
        i_far.drive_pin(1'b1);
        rd("rise_skip", OFF_DOWN_COUNT, 8'h10);
        i_far.drive_pin(1'b0);
        rd("fall_hit", OFF_DOWN_COUNT, 8'h0F);
        wr(OFF_CTRL_TWO, 8'h28);
        i_far.drive_pin(1'b1);
        rd("rise_hit", OFF_DOWN_COUNT, 8'h0E);
        i_far.drive_pin(1'b0);
        rd("fall_skip", OFF_DOWN_COUNT, 8'h0E);
        // pulse: frame of 4 ticks, then of 256, duty kept within each
        wr(OFF_CTRL_TWO, CTRL_TWO_RST);
        wr(OFF_PULSE_DUTY, 8'h01);
        wr(OFF_DOWN_COUNT, 8'h03);
        meas(OFF_CTRL_ONE, 8'h83, 1'b0, 400, 16'd100);
        chk("pulse_oe", {15'h0000, poe}, 16'h0001);
        meas(OFF_CTRL_ONE, 8'hC3, 1'b0, 400, 16'd300);
        meas(OFF_PULSE_DUTY, 8'h00, 1'b0, 400, 16'd400);
        wr(OFF_CTRL_ONE, 8'h83);
        wr(OFF_DOWN_COUNT, 8'hFF);
        meas(OFF_PULSE_DUTY, 8'hFF, 1'b0, 512, 16'd510);
        wr(OFF_CTRL_ONE, 8'h03);
        wr(OFF_DOWN_COUNT, 8'h03);
        chk("pulse_oe", {15'h0000, poe}, 16'h0000);
        // tone from the raw source, then from underflow
        meas(OFF_TONE_CTRL, 8'h81, 1'b1, 400, 16'd200);
        chk("tone_oe", {15'h0000, toe}, 16'h0001);
        meas(OFF_TONE_CTRL, 8'h87, 1'b1, 512, 16'd4);
        meas(OFF_TONE_CTRL, 8'h88, 1'b1, 400, 16'd100);
        meas(OFF_TONE_CTRL, 8'h89, 1'b1, 400, 16'd50);
        wr(OFF_TONE_CTRL, TONE_CTRL_RST);
        repeat (2) @(posedge clk);
        chk("tone_oe", {15'h0000, toe}, 16'h0000);
        conclude();
    end
endmodule : testbench
